// ### core/csr_pkg.sv
// Constants and state type for the core status and option register bank
package csr_pkg;

  // Status register bit positions
  localparam int unsigned ST_C        = 0;
  localparam int unsigned ST_NIB_C    = 1;
  localparam int unsigned ST_Z        = 2;
  localparam int unsigned ST_PWRDN    = 3;
  localparam int unsigned ST_TIMEOUT  = 4;
  localparam int unsigned ST_BANK_LO  = 5;
  localparam int unsigned ST_BANK_HI  = 6;
  localparam int unsigned ST_IND_BANK = 7;

  // Option register bit positions
  localparam int unsigned OPT_RATE_LSB = 0;
  localparam int unsigned OPT_RATE_MSB = 2;
  localparam int unsigned OPT_OWNER    = 3;
  localparam int unsigned OPT_T0_EDGE  = 4;
  localparam int unsigned OPT_T0_SRC   = 5;
  localparam int unsigned OPT_EDGE     = 6;
  localparam int unsigned OPT_PUDIS    = 7;

  // Register indices (data-space file addresses)
  localparam logic [7:0] IDX_STATUS_B0 = 8'h03;
  localparam logic [7:0] IDX_STATUS_B1 = 8'h83;
  localparam logic [7:0] IDX_OPTION    = 8'h81;

  // APB byte addresses, four times the index
  localparam logic [11:0] ADDR_STATUS_B0 = {2'b00, IDX_STATUS_B0, 2'b00};
  localparam logic [11:0] ADDR_STATUS_B1 = {2'b00, IDX_STATUS_B1, 2'b00};
  localparam logic [11:0] ADDR_OPTION    = {2'b00, IDX_OPTION, 2'b00};

  // Values after reset
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;

  // Status bits that a plain write may change
  localparam logic [7:0] STATUS_WR_MASK = 8'he7;

  // Arithmetic flag bits of the status register
  localparam logic [7:0] STATUS_FLAG_MASK = 8'h07;

  // Base of data bank one
  localparam logic [7:0] BANK1_BASE = 8'h80;

  // Complete state of the register bank
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  option;
    logic [31:0] prdata;
    logic [7:0]  core_rd;
  } csr_state_t;

endpackage

// ### core/csr_apb_dec.sv
// APB address decode and handshake for the register bank
`timescale 1ns/1ps
`default_nettype none
module csr_apb_dec
  import csr_pkg::*;
(
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        core_wr_busy,
  output logic             hit_status,
  output logic             hit_option,
  output logic             setup_phase,
  output logic             wr_fire,
  output logic             pready,
  output logic             pslverr
);

  // Address decode
  always_comb begin
    hit_status = 1'b0;
    hit_option = 1'b0;
    if (paddr == ADDR_STATUS_B0 || paddr == ADDR_STATUS_B1) begin
      hit_status = 1'b1;
    end else if (paddr == ADDR_OPTION) begin
      hit_option = 1'b1;
    end
  end

  // Handshake, writes wait while the core writes
  assign setup_phase = psel & ~penable;
  assign pready      = ~(pwrite & core_wr_busy);
  assign pslverr     = psel & penable & pready & ~(hit_status | hit_option);
  assign wr_fire     = psel & penable & pready & pwrite;

endmodule // csr_apb_dec
`default_nettype wire

// ### core/csr_presc_dec.sv
// Prescaler ratio decode from the option register
`timescale 1ns/1ps
`default_nettype none
module csr_presc_dec
  import csr_pkg::*;
(
  input  wire logic [7:0] option,
  output logic [3:0]      timer0_div_log2,
  output logic [3:0]      watchdog_div_log2
);

  logic [3:0] rate;

  // Rate field widened for arithmetic
  assign rate = {1'b0, option[OPT_RATE_MSB:OPT_RATE_LSB]};

  // Owner gets the ratio, the other path runs 1:1
  always_comb begin
    if (option[OPT_OWNER]) begin
      timer0_div_log2   = 4'h0;
      watchdog_div_log2 = rate;
    end else begin
      timer0_div_log2   = 4'(rate + 4'h1);
      watchdog_div_log2 = 4'h0;
    end
  end

endmodule // csr_presc_dec
`default_nettype wire

// ### core/csr_core_regs.sv
// Core status and option registers with APB access and core-side ports
//
// How it works
// - Instructions may write the status register like any other register.
// - Flag-updating instructions set zero, digit carry, carry from results, not data.
// - Timeout and power-down flags ignore every write.
// - Clearing status gives upper three zero, flags kept, zero flag one.
// - Subtraction stores carry and digit carry as inverted borrow.
// - Status answers at file address 03h and 83h.
// - Reset loads bank bit zero, timeout and power-down one.
// - Option bit 7 high disables all port B pull-ups.
// - Option bit 6 picks rising or falling external interrupt edge.
// - Option bit 5 picks external pin or instruction clock for timer0.
// - Option bit 4 picks falling or rising external timer0 edge.
// - Option bit 3 gives the prescaler to watchdog or timer0.
// - Rate n divides timer0 by 2^(n+1), watchdog by 2^n.
// - Sleep clears power-down flag and sets timeout flag.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core data-space access
  input  wire logic [6:0]  core_file_addr,
  input  wire logic        core_wr_en,
  input  wire logic [7:0]  core_wr_data,
  output logic [7:0]       core_rd_data,
  output logic [7:0]       data_addr_full,
  // ALU outcome and flag update strobes
  input  wire logic [2:0]  core_flag_upd,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_digit_carry,
  input  wire logic        alu_is_sub,
  // Special instructions and watchdog events
  input  wire logic        core_sleep,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        watchdog_timeout,
  // Status view
  output logic [7:0]       status_out,
  output logic             bank_select_low,
  output logic             timeout_flag,
  output logic             powerdown_flag,
  // Configuration outputs
  output logic             port_b_pullup_disable,
  output logic             ext_irq_edge_sel,
  output logic             timer0_source_sel,
  output logic             timer0_edge_sel,
  output logic             prescaler_owner,
  output logic [2:0]       prescale_rate_sel,
  output logic [3:0]       timer0_div_log2,
  output logic [3:0]       watchdog_div_log2
);

  // Flag update strobe positions
  localparam int unsigned UPD_C = 0;
  localparam int unsigned UPD_NIB = 1;
  localparam int unsigned UPD_Z = 2;

  csr_state_t s_r;
  csr_state_t s_nxt;

  logic       apb_hit_status;
  logic       apb_hit_option;
  logic       apb_setup;
  logic       apb_wr_fire;
  logic [7:0] core_addr;
  logic       core_hit_status;
  logic       core_hit_option;
  logic       core_wr_status;
  logic       core_wr_option;
  logic       flag_c;
  logic       flag_nib;
  logic       flag_z;

  // Zero test of an ALU result
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Apply a write through a writable-bit mask
  function automatic logic [7:0] masked_write(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] mask
  );
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Carry as stored, inverted borrow on subtraction
  function automatic logic carry_view(
    input logic raw,
    input logic is_sub
  );
    return is_sub ? ~raw : raw;
  endfunction

  // APB decode and handshake
  csr_apb_dec u_apb_dec (
    .paddr        (paddr),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .core_wr_busy (core_wr_en),
    .hit_status   (apb_hit_status),
    .hit_option   (apb_hit_option),
    .setup_phase  (apb_setup),
    .wr_fire      (apb_wr_fire),
    .pready       (pready),
    .pslverr      (pslverr)
  );

  // Prescaler ratio decode
  csr_presc_dec u_presc_dec (
    .option            (s_r.option),
    .timer0_div_log2   (timer0_div_log2),
    .watchdog_div_log2 (watchdog_div_log2)
  );

  // Full data address from bank bit and file address
  assign core_addr = {s_r.status[ST_BANK_LO], core_file_addr};

  // Status seen in either bank
  assign core_hit_status = (core_file_addr == IDX_STATUS_B0[6:0]);
  assign core_hit_option = (core_addr == IDX_OPTION);
  assign core_wr_status  = core_wr_en & core_hit_status;
  assign core_wr_option  = core_wr_en & core_hit_option;

  // Flag values from the ALU outcome
  assign flag_z   = is_zero(alu_result);
  assign flag_c   = carry_view(alu_carry, alu_is_sub);
  assign flag_nib = carry_view(alu_digit_carry, alu_is_sub);

  // Next state of the register bank
  always_comb begin
    s_nxt = s_r;

    // Plain writes, core first, APB waits on a clash
    if (core_wr_status && (core_flag_upd != 3'b000)) begin
      // Flag-updating instruction, written flag bits dropped
      s_nxt.status = masked_write(s_r.status, core_wr_data, STATUS_WR_MASK & ~STATUS_FLAG_MASK);
    end else if (core_wr_status) begin
      s_nxt.status = masked_write(s_r.status, core_wr_data, STATUS_WR_MASK);
    end else if (apb_wr_fire && apb_hit_status) begin
      s_nxt.status = masked_write(s_r.status, pwdata[7:0], STATUS_WR_MASK);
    end

    // Option register fully writable
    if (core_wr_option) begin
      s_nxt.option = core_wr_data;
    end else if (apb_wr_fire && apb_hit_option) begin
      s_nxt.option = pwdata[7:0];
    end

    // Arithmetic flags override any written value
    if (core_flag_upd[UPD_Z]) begin
      s_nxt.status[ST_Z] = flag_z;
    end
    if (core_flag_upd[UPD_NIB]) begin
      s_nxt.status[ST_NIB_C] = flag_nib;
    end
    if (core_flag_upd[UPD_C]) begin
      s_nxt.status[ST_C] = flag_c;
    end

    // Watchdog clear restores both reset flags
    if (watchdog_clear_instr) begin
      s_nxt.status[ST_TIMEOUT] = 1'b1;
      s_nxt.status[ST_PWRDN]   = 1'b1;
    end

    // Sleep entry
    if (core_sleep) begin
      s_nxt.status[ST_PWRDN]   = 1'b0;
      s_nxt.status[ST_TIMEOUT] = 1'b1;
    end

    // Timeout event wins over a same-cycle set
    if (watchdog_timeout) begin
      s_nxt.status[ST_TIMEOUT] = 1'b0;
    end

    // APB read data captured in the setup cycle
    if (apb_setup) begin
      if (apb_hit_status) begin
        s_nxt.prdata = {24'h00_0000, s_r.status};
      end else if (apb_hit_option) begin
        s_nxt.prdata = {24'h00_0000, s_r.option};
      end else begin
        s_nxt.prdata = 32'h0000_0000;
      end
    end

    // Core read data, one cycle after the address
    if (core_hit_status) begin
      s_nxt.core_rd = s_r.status;
    end else if (core_hit_option) begin
      s_nxt.core_rd = s_r.option;
    end else begin
      s_nxt.core_rd = 8'h00;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.status  <= STATUS_RST;
      s_r.option  <= OPTION_RST;
      s_r.prdata  <= 32'h0000_0000;
      s_r.core_rd <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus and core read outputs
  assign prdata         = s_r.prdata;
  assign core_rd_data   = s_r.core_rd;
  assign data_addr_full = core_addr;

  // Status view
  assign status_out      = s_r.status;
  assign bank_select_low = s_r.status[ST_BANK_LO];
  assign timeout_flag    = s_r.status[ST_TIMEOUT];
  assign powerdown_flag  = s_r.status[ST_PWRDN];

  // Configuration fields of the option register
  assign port_b_pullup_disable = s_r.option[OPT_PUDIS];
  assign ext_irq_edge_sel      = s_r.option[OPT_EDGE];
  assign timer0_source_sel     = s_r.option[OPT_T0_SRC];
  assign timer0_edge_sel       = s_r.option[OPT_T0_EDGE];
  assign prescaler_owner       = s_r.option[OPT_OWNER];
  assign prescale_rate_sel     = s_r.option[OPT_RATE_MSB:OPT_RATE_LSB];

endmodule // csr_core_regs
`default_nettype wire

// ### bench/csr_core_regs_checker.sv
// Concurrent checks on the status and option register bank ports
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_checker
  import csr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_wr_en,
  input wire logic [2:0]  core_flag_upd,
  input wire logic [7:0]  alu_result,
  input wire logic        alu_carry,
  input wire logic        alu_is_sub,
  input wire logic        core_sleep,
  input wire logic        watchdog_clear_instr,
  input wire logic        watchdog_timeout,
  input wire logic [7:0]  status_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mapped decode of the access phase
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr inside {ADDR_STATUS_B0, ADDR_STATUS_B1, ADDR_OPTION};
  a_reset_flags_hold: assert property (!core_sleep && !watchdog_clear_instr && !watchdog_timeout
    |=> $stable(status_out[4:3])) else $error("flag bits moved without event");
  a_sleep_flags: assert property (core_sleep && !watchdog_timeout |=> status_out[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_timeout_clear: assert property (watchdog_timeout |=> !status_out[4]) else $error("timeout kept");
  a_zero_result: assert property (core_flag_upd[2] |=> status_out[2] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  a_sub_borrow: assert property (core_flag_upd[0] && alu_is_sub |=> status_out[0] == !$past(alu_carry))
    else $error("borrow polarity wrong");
  a_unmapped_err: assert property (acc && pready && !hit |-> pslverr) else $error("no error on unmapped");
  a_mapped_ok: assert property (acc && hit |-> !pslverr) else $error("error on mapped");
  a_apb_status_wr: assert property (acc && pready && pwrite && paddr == ADDR_STATUS_B1 && !core_wr_en
    |=> status_out[7:5] == $past(pwdata[7:5])) else $error("status write lost");
  c_sleep: cover property (core_sleep);
  c_unmapped: cover property (acc && !hit);
  c_sub: cover property (core_flag_upd[0] && alu_is_sub);
endmodule // csr_core_regs_checker
bind csr_core_regs csr_core_regs_checker u_chk (
  .pclk                 (pclk),
  .presetn              (presetn),
  .paddr                (paddr),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .pwdata               (pwdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .core_wr_en           (core_wr_en),
  .core_flag_upd        (core_flag_upd),
  .alu_result           (alu_result),
  .alu_carry            (alu_carry),
  .alu_is_sub           (alu_is_sub),
  .core_sleep           (core_sleep),
  .watchdog_clear_instr (watchdog_clear_instr),
  .watchdog_timeout     (watchdog_timeout),
  .status_out           (status_out)
);
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the status and option register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, core_wr_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  core_file_addr;
  logic [7:0]  core_wr_data, core_rd_data, data_addr_full, alu_result, status_out;
  logic [2:0]  core_flag_upd, prescale_rate_sel;
  logic        alu_carry, alu_digit_carry, alu_is_sub, core_sleep, watchdog_clear_instr, watchdog_timeout, er;
  logic        bank_select_low, timeout_flag, powerdown_flag, port_b_pullup_disable, ext_irq_edge_sel;
  logic        timer0_source_sel, timer0_edge_sel, prescaler_owner;
  logic [3:0]  timer0_div_log2, watchdog_div_log2, v;
  int          error_cnt, checks_done;
  csr_core_regs DUT (
    .pclk                  (pclk),
    .presetn               (presetn),
    .paddr                 (paddr),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .core_file_addr        (core_file_addr),
    .core_wr_en            (core_wr_en),
    .core_wr_data          (core_wr_data),
    .core_rd_data          (core_rd_data),
    .data_addr_full        (data_addr_full),
    .core_flag_upd         (core_flag_upd),
    .alu_result            (alu_result),
    .alu_carry             (alu_carry),
    .alu_digit_carry       (alu_digit_carry),
    .alu_is_sub            (alu_is_sub),
    .core_sleep            (core_sleep),
    .watchdog_clear_instr  (watchdog_clear_instr),
    .watchdog_timeout      (watchdog_timeout),
    .status_out            (status_out),
    .bank_select_low       (bank_select_low),
    .timeout_flag          (timeout_flag),
    .powerdown_flag        (powerdown_flag),
    .port_b_pullup_disable (port_b_pullup_disable),
    .ext_irq_edge_sel      (ext_irq_edge_sel),
    .timer0_source_sel     (timer0_source_sel),
    .timer0_edge_sel       (timer0_edge_sel),
    .prescaler_owner       (prescaler_owner),
    .prescale_rate_sel     (prescale_rate_sel),
    .timer0_div_log2       (timer0_div_log2),
    .watchdog_div_log2     (watchdog_div_log2)
  );
  // Clock at 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask
  // One core instruction cycle; sx is sub, sleep, clear, timeout
  task automatic ev(input logic [6:0] a, input logic we, input logic [7:0] d, input logic [2:0] u,
                    input logic [3:0] sx);
    @(posedge pclk);
    {core_file_addr, core_wr_en, core_wr_data, core_flag_upd} <= {a, we, d, u};
    {alu_is_sub, core_sleep, watchdog_clear_instr, watchdog_timeout} <= sx;
    @(posedge pclk);
    {core_wr_en, core_flag_upd, alu_is_sub, core_sleep, watchdog_clear_instr, watchdog_timeout} <= 8'h00;
    @(negedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, core_wr_en, core_file_addr, core_wr_data} = '0;
    {core_flag_upd, alu_result, alu_carry, alu_digit_carry, alu_is_sub} = '0;
    {core_sleep, watchdog_clear_instr, watchdog_timeout} = 3'b000;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS_B0, 32'h0000_0000); chk(rd, 32'h0000_0018);
    apb(1'b0, ADDR_STATUS_B1, 32'h0000_0000); chk(rd, 32'h0000_0018);
    apb(1'b0, ADDR_OPTION, 32'h0000_0000); chk(rd, 32'h0000_00ff);
    apb(1'b0, 12'h100, 32'h0000_0000); chk({er, rd[30:0]}, 32'h8000_0000);
    $display("test reset and map done");
    apb(1'b1, ADDR_STATUS_B1, 32'h0000_00e7); chk(status_out, 8'hff);
    ev(7'h03, 1'b1, 8'h00, 3'b100, 4'h0); chk(status_out, 8'h1f);
    @(posedge pclk);
    alu_result <= 8'h12;
    alu_carry  <= 1'b1;
    ev(7'h03, 1'b1, 8'hff, 3'b111, 4'h8); chk(status_out, 8'hfa);
    chk(data_addr_full, 8'h83);
    ev(7'h01, 1'b0, 8'h00, 3'b000, 4'h0); chk(core_rd_data, 8'hff);
    chk(bank_select_low, 1'b1);
    ev(7'h01, 1'b1, 8'h5a, 3'b000, 4'h0);
    ev(7'h01, 1'b0, 8'h00, 3'b000, 4'h0); chk(core_rd_data, 8'h5a);
    apb(1'b1, ADDR_STATUS_B0, 32'h0000_0000); chk(status_out, 8'h18);
    chk(data_addr_full, 8'h01);
    $display("test status writes done");
    ev(7'h00, 1'b0, 8'h00, 3'b000, 4'h4); chk({timeout_flag, powerdown_flag}, 2'b10);
    ev(7'h00, 1'b0, 8'h00, 3'b000, 4'h1); chk(status_out, 8'h00);
    ev(7'h00, 1'b0, 8'h00, 3'b000, 4'h2); chk(status_out, 8'h18);
    ev(7'h00, 1'b0, 8'h00, 3'b000, 4'h5); chk(status_out, 8'h00);
    $display("test power flags done");
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      apb(1'b1, ADDR_OPTION, {28'h0, v});
      chk(timer0_div_log2, v[3] ? 4'h0 : {1'b0, v[2:0]} + 4'h1);
      chk(watchdog_div_log2, v[3] ? {1'b0, v[2:0]} : 4'h0);
      chk({prescaler_owner, prescale_rate_sel}, v);
    end
    // Core status write clashes with the APB access phase
    fork
      apb(1'b1, ADDR_OPTION, 32'h0000_00a0);
      begin
        @(posedge pclk);
        ev(7'h03, 1'b1, 8'h20, 3'b000, 4'h0);
      end
    join
    chk(status_out, 8'h20);
    chk(bank_select_low, 1'b1);
    chk({port_b_pullup_disable, ext_irq_edge_sel, timer0_source_sel, timer0_edge_sel}, 4'ha);
    apb(1'b1, ADDR_OPTION, 32'h0000_0050);
    apb(1'b0, ADDR_OPTION, 32'h0000_0000); chk(rd, 32'h0000_0050);
    $display("test option done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
